// *** hw/ssc_pkg.sv ***
package ssc_pkg;
    // Switch bit positions within the DIP switch bank
    localparam int SW_PULSE_MODE = 0;
    localparam int SW_RES_LOCK = 2;
    localparam int SW_RES_SEL = 3;
    localparam int DIP_W = 4;
    localparam logic [3:0] CUR_DEFAULT = 4'hF;
    localparam int CUR_RATE_W = 11;
    // Rate step in half tenths of a percent; halved with rounding gives (n+1)/16
    localparam logic [10:0] CUR_RATE_STEP = 11'h07D;
    localparam logic [10:0] CUR_RATE_FULL = 11'h3E8;
    localparam int RES_W = 16;
    localparam logic [15:0] RES_TAB_0 = 16'h03E8;
    localparam logic [15:0] RES_TAB_1 = 16'h01F4;
    localparam logic [15:0] RES_TAB_2 = 16'h07D0;
    localparam logic [15:0] RES_TAB_3 = 16'h0FA0;
    localparam logic [15:0] RES_TAB_ALT = 16'h2710;
    // Alarm blink timing
    localparam int BLINK_MS = 200;
    localparam int CLK_HZ = 20000000;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int ALM_W = 4;
    typedef enum logic [1:0] {
        SSC_IDLE = 2'b00,
        SSC_ON = 2'b01,
        SSC_OFF = 2'b11,
        SSC_GAP = 2'b10
    } ssc_blink_t;
endpackage

// *** hw/ssc_sync.sv ***
module ssc_sync
    import ssc_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ssc_sync_st_t;
    ssc_sync_st_t st_q, st_d;
    always_comb begin
        st_d.s1 = d_i;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign q_o = st_q.s2;
endmodule

// *** hw/ssc_decoder.sv ***
// How it works
// [RULE1] Switches are captured once after power-up reset and then held.
// [RULE2] Shaft resolution comes from latched switches 3 and 4.
// [RULE3] Resolution select input acts only while switch 3 is off.
// [RULE4] Switch 1 on: step pulse carries steps, rotation sense sets direction.
// [RULE5] Switch 1 off: clockwise and counter-clockwise pulses step each way.
// [RULE6] Controller must emit pulses in the format the selected mode expects.
// [RULE7] Sixteen-level current dial scales maximum current, code F is full.
// [RULE8] Code n gives rate (n+1)/16; default code F, 100 percent.
// [RULE9] Active alarm blinks the indicator, blink count per group names it.
// [RULE10] Motor energised, ready, pulses accepted only after excitation enable.
// [RULE11] Resolution per switch combination comes from a configurable table.
module ssc_decoder
    import ssc_pkg::*;
#(
    parameter logic [15:0] RES_0 = RES_TAB_0,
    parameter logic [15:0] RES_1 = RES_TAB_1,
    parameter logic [15:0] RES_2 = RES_TAB_2,
    parameter logic [15:0] RES_3 = RES_TAB_3,
    parameter logic [15:0] RES_ALT = RES_TAB_ALT,
    parameter int BLINK_CYCLES = BLINK_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] dip_sw_i,
    input wire logic [3:0] cur_dial_i,
    input wire logic resolution_select_i,
    input wire logic excitation_enable_i,
    input wire logic step_pulse_i,
    input wire logic rotation_sense_i,
    input wire logic cw_pulse_i,
    input wire logic ccw_pulse_i,
    input wire logic [3:0] alarm_code_i,
    output logic single_pulse_mode_o,
    output logic [15:0] resolution_o,
    output logic [10:0] current_rate_o,
    output logic [3:0] current_code_o,
    output logic energise_o,
    output logic ready_o,
    output logic step_o,
    output logic dir_cw_o,
    output logic alarm_led_o
);
    logic [3:0] dip_s;
    logic [3:0] dial_s;
    logic [3:0] alm_s;
    logic rsel_s;
    logic exc_s;
    logic pls_s;
    logic dir_s;
    logic cw_s;
    logic ccw_s;

    // Every pin, switches included, passes the same two-flop bank
    ssc_sync #(.W(18)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .d_i({
            dip_sw_i,
            cur_dial_i,
            alarm_code_i,
            resolution_select_i,
            excitation_enable_i,
            step_pulse_i,
            rotation_sense_i,
            cw_pulse_i,
            ccw_pulse_i
        }),
        .q_o({
            dip_s,
            dial_s,
            alm_s,
            rsel_s,
            exc_s,
            pls_s,
            dir_s,
            cw_s,
            ccw_s
        })
    );

    typedef struct packed {
        logic [1:0] warm;
        logic latched;
        logic [3:0] dip;
        logic [3:0] cur;
        logic [15:0] res;
        logic [10:0] rate;
        logic ready;
        logic pls_p;
        logic cw_p;
        logic ccw_p;
        logic step;
        logic dir;
        ssc_blink_t bst;
        logic [3:0] bcnt;
        logic [31:0] tmr;
        logic led;
    } ssc_st_t;
    ssc_st_t st_q, st_d;

    always_comb begin
        logic [15:0] base;
        logic pls_edge;
        logic cw_edge;
        logic ccw_edge;
        logic tick;
        base = '0;
        // Edges against the previous synchronised level, so a held pin gives one step
        pls_edge = pls_s && !st_q.pls_p;
        cw_edge = cw_s && !st_q.cw_p;
        ccw_edge = ccw_s && !st_q.ccw_p;
        // Blink divider: one-cycle enable each time the period counter runs out
        tick = (st_q.tmr == 32'h0);
        st_d = st_q;
        // Wait for synchronisers to fill before taking the switches
        if (st_q.warm != 2'h3) begin
            st_d.warm = st_q.warm + 2'h1;
        end else if (!st_q.latched) begin
            st_d.latched = 1'b1; // [RULE1]
            st_d.dip = dip_s; // [RULE1]
            st_d.cur = dial_s; // [RULE1]
        end
        // Resolution table, indexed by switches 3 and 4
        case ({st_q.dip[SW_RES_SEL], st_q.dip[SW_RES_LOCK]})
            2'h0: base = RES_0; // [RULE11]
            2'h1: base = RES_1;
            2'h2: base = RES_2;
            2'h3: base = RES_3;
            default: base = RES_0;
        endcase
        if (rsel_s && !st_q.dip[SW_RES_LOCK]) begin
            st_d.res = RES_ALT; // [RULE3]
        end else begin
            st_d.res = base; // [RULE2]
        end
        // Taken from the next code so that rate and code never show a stale pair
        st_d.rate = 11'(((({7'h00, st_d.cur} + 11'h001) * CUR_RATE_STEP) + 11'h001)
                    >> 1); // [RULE8]
        if (st_d.cur == 4'hF) begin
            st_d.rate = CUR_RATE_FULL; // [RULE7]
        end
        st_d.ready = st_q.latched && exc_s; // [RULE10]
        st_d.pls_p = pls_s;
        st_d.cw_p = cw_s;
        st_d.ccw_p = ccw_s;
        st_d.step = 1'b0;
        // A cw edge wins over a ccw edge in the same cycle
        if (st_q.ready) begin
            if (st_q.dip[SW_PULSE_MODE]) begin
                if (pls_edge) begin
                    st_d.step = 1'b1; // [RULE4]
                    st_d.dir = !dir_s; // [RULE4]
                end
            end else if (cw_edge) begin
                st_d.step = 1'b1; // [RULE5]
                st_d.dir = 1'b1;
            end else if (ccw_edge) begin
                st_d.step = 1'b1; // [RULE5]
                st_d.dir = 1'b0;
            end
        end
        // Blink groups: alarm code n gives n blinks, then a long gap
        st_d.tmr = tick ? 32'(BLINK_CYCLES - 1) : st_q.tmr - 32'h1;
        case (st_q.bst)
            SSC_IDLE: begin
                st_d.led = 1'b0;
                st_d.tmr = 32'(BLINK_CYCLES - 1);
                if (alm_s != 4'h0) begin
                    st_d.bst = SSC_ON; // [RULE9]
                    st_d.bcnt = alm_s;
                    st_d.led = 1'b1;
                end
            end
            SSC_ON: begin
                if (tick) begin
                    st_d.bst = SSC_OFF;
                    st_d.led = 1'b0;
                    st_d.bcnt = st_q.bcnt - 4'h1;
                end
            end
            SSC_OFF: begin
                if (tick) begin
                    if (st_q.bcnt == 4'h0) begin
                        st_d.bst = SSC_GAP;
                        st_d.bcnt = 4'h4;
                    end else begin
                        st_d.bst = SSC_ON; // [RULE9]
                        st_d.led = 1'b1;
                    end
                end
            end
            SSC_GAP: begin
                if (tick) begin
                    st_d.bcnt = st_q.bcnt - 4'h1;
                    if (st_q.bcnt == 4'h1) begin
                        st_d.bst = SSC_IDLE;
                    end
                end
            end
            default: st_d.bst = SSC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q <= '0;
            st_q.cur <= CUR_DEFAULT; // [RULE8]
            st_q.rate <= CUR_RATE_FULL;
            st_q.res <= RES_0;
            st_q.bst <= SSC_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign single_pulse_mode_o = st_q.dip[SW_PULSE_MODE];
    assign resolution_o = st_q.res;
    assign current_rate_o = st_q.rate;
    assign current_code_o = st_q.cur;
    assign energise_o = st_q.ready; // [RULE10]
    assign ready_o = st_q.ready;
    assign step_o = st_q.step;
    assign dir_cw_o = st_q.dir;
    assign alarm_led_o = st_q.led;
endmodule

// *** testbench/ssc_decoder_assertions.sv ***
module ssc_decoder_checker
    import ssc_pkg::*;
#(
    parameter logic [15:0] RES_ALT = RES_TAB_ALT
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [3:0] dip_sw_i,
    input wire logic excitation_enable_i,
    input wire logic step_pulse_i,
    input wire logic rotation_sense_i,
    input wire logic cw_pulse_i,
    input wire logic ccw_pulse_i,
    input wire logic single_pulse_mode_o,
    input wire logic [15:0] resolution_o,
    input wire logic [10:0] current_rate_o,
    input wire logic [3:0] current_code_o,
    input wire logic energise_o,
    input wire logic ready_o,
    input wire logic step_o,
    input wire logic dir_cw_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] n_w;
    logic lock_q;
    assign n_w = {7'h00, current_code_o} + 11'h001;
    // Switches must stay put through reset, so the lock position is taken there
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lock_q <= dip_sw_i[SW_RES_LOCK];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    step_width_a: assert property (step_o |=> !step_o) else $error("step too long");
    unready_a: assert property (!ready_o && !$past(ready_o) |-> !step_o)
        else $error("step while not ready");
    ready_enable_a: assert property (ready_o |-> energise_o && $past(excitation_enable_i, 3))
        else $error("ready without enable");
    mode_held_a: assert property (ready_o |-> $stable(single_pulse_mode_o))
        else $error("mode changed");
    rate_map_a: assert property (int'(current_rate_o) == ((current_code_o == 4'hF) ?
        int'(CUR_RATE_FULL) : (int'(n_w) * 1000 + 8) / 16)) else $error("rate wrong");
    res_lock_a: assert property (ready_o && lock_q |-> resolution_o != RES_ALT)
        else $error("select not ignored");
    single_step_a: assert property (ready_o && single_pulse_mode_o && $rose(step_pulse_i)
        |-> ##3 (step_o && dir_cw_o == !rotation_sense_i)) else $error("single step");
    dual_step_a: assert property (ready_o && !single_pulse_mode_o && $rose(cw_pulse_i)
        |-> ##3 (step_o && dir_cw_o)) else $error("dual step");
    dual_ccw_a: assert property (ready_o && !single_pulse_mode_o && $rose(ccw_pulse_i)
        && !$rose(cw_pulse_i) |-> ##3 (step_o && !dir_cw_o)) else $error("dual ccw step");
endmodule
bind ssc_decoder ssc_decoder_checker #(.RES_ALT(RES_ALT)) i_chk (.*);

// *** testbench/ssc_ctl_model.sv ***
module ssc_ctl_model (
    input wire logic clk_i,
    input wire logic single_i,
    output logic step_pulse_o,
    output logic rotation_sense_o,
    output logic cw_pulse_o,
    output logic ccw_pulse_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {step_pulse_o, rotation_sense_o, cw_pulse_o, ccw_pulse_o} = 4'h0;
    // Two cycles high, two low: one cycle of margin over the shortest legal step
    task send(input logic cw);
        @(negedge clk_i);
        rotation_sense_o = !cw;
        if (single_i) step_pulse_o = 1'b1;
        else if (cw) cw_pulse_o = 1'b1;
        else ccw_pulse_o = 1'b1;
        repeat (2) @(negedge clk_i);
        {step_pulse_o, cw_pulse_o, ccw_pulse_o} = 3'h0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule

// *** testbench/stepper_switch_config_decoder_test.sv ***
module stepper_switch_config_decoder_test;
    import ssc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, srst = 1, sel = 0, en = 0, mode = 1, sp, rs, cw, ccw;
    logic spm, ener, rdy, stp, dcw, led, led_p;
    logic [3:0] dip = 4'h1, dial = 4'h7, alarm = 4'h0, code;
    logic [15:0] res;
    logic [10:0] rate;
    int n_fail = 0, checks_done = 0, steps = 0, cws = 0, blinks = 0;
    ssc_decoder #(.BLINK_CYCLES(4)) i_ssc_decoder (.clk_i(clk), .srst_i(srst), .dip_sw_i(dip),
        .cur_dial_i(dial), .resolution_select_i(sel), .excitation_enable_i(en),
        .step_pulse_i(sp), .rotation_sense_i(rs), .cw_pulse_i(cw), .ccw_pulse_i(ccw),
        .alarm_code_i(alarm), .single_pulse_mode_o(spm), .resolution_o(res),
        .current_rate_o(rate), .current_code_o(code), .energise_o(ener), .ready_o(rdy),
        .step_o(stp), .dir_cw_o(dcw), .alarm_led_o(led));
    ssc_ctl_model i_ssc_ctl_model (.clk_i(clk), .single_i(mode), .step_pulse_o(sp),
        .rotation_sense_o(rs), .cw_pulse_o(cw), .ccw_pulse_o(ccw));
    initial forever #25 clk = ~clk;
    // Counted on the falling edge, where the one-cycle step pulse is settled
    always @(negedge clk) if (stp === 1'b1) begin
        steps++;
        cws += (dcw === 1'b1);
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Switches only load on reset release, so each setup is a power cycle
    task power(input logic [3:0] d, input logic [3:0] c, input logic s);
        @(negedge clk);
        {srst, en, dip, dial, sel} = {1'b1, 1'b0, d, c, s};
        repeat (20) @(negedge clk);
        chk("code_rst", 16'h000F, 16'(code));
        chk("rate_rst", 16'h03E8, 16'(rate));
        chk("res_rst", RES_TAB_0, res);
        srst = 1'b0;
        repeat (10) @(negedge clk);
    endtask
    task pulses(input int n, input int ncw);
        en = 1'b1;
        repeat (5) @(negedge clk);
        chk("ready", 16'h0003, 16'({ener, rdy}));
        steps = 0;
        cws = 0;
        for (int i = 0; i < n; i++) i_ssc_ctl_model.send(i < ncw);
        repeat (5) @(negedge clk);
        chk("steps", 16'(n), 16'(steps));
        chk("cw_steps", 16'(ncw), 16'(cws));
    endtask
    initial begin
        power(4'h1, 4'h7, 1'b0);
        chk("mode1", 16'h0001, 16'(spm));
        chk("rate7", 16'h01F4, 16'(rate));
        chk("code7", 16'h0007, 16'(code));
        chk("res0", RES_TAB_0, res);
        {sel, dip, dial} = {1'b1, 4'h0, 4'h3};
        i_ssc_ctl_model.send(1'b1);
        chk("refused", 16'h0000, 16'(steps));
        chk("unready", 16'h0000, 16'({ener, rdy}));
        chk("res_alt", RES_TAB_ALT, res);
        chk("held", 16'h0001, 16'(spm));
        chk("held_code", 16'h0007, 16'(code));
        pulses(3, 2);
        $display("test single pulse done");
        mode = 1'b0;
        power(4'hC, 4'hE, 1'b1);
        chk("mode2", 16'h0000, 16'(spm));
        chk("rateE", 16'h03AA, 16'(rate));
        chk("res3", RES_TAB_3, res);
        pulses(2, 1);
        chk("alarm_idle", 16'h0000, 16'(led));
        alarm = 4'h2;
        led_p = 1'b0;
        // One group: two blinks, then a gap long enough that the next group starts later
        repeat (30) @(negedge clk) begin
            if (led === 1'b1 && led_p !== 1'b1) blinks++;
            led_p = led;
        end
        chk("alarm_blinks", 16'h0002, 16'(blinks));
        $display("test dual pulse done");
        power(4'h4, 4'hF, 1'b1);
        chk("res1", RES_TAB_1, res);
        chk("rateF", 16'h03E8, 16'(rate));
        power(4'h8, 4'h0, 1'b0);
        chk("res2", RES_TAB_2, res);
        chk("rate0", 16'h003F, 16'(rate));
        $display("test table corners done");
        results();
    end
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule
